// file: src/lpbo_pkg.sv
package lpbo_pkg;
  localparam logic [7:0] LPBO_ADDR_PHASE0 = 8'h00;
  localparam logic [7:0] LPBO_ADDR_PHASE1 = 8'h04;
  localparam logic [7:0] LPBO_ADDR_MASTER = 8'h08;
  localparam logic [7:0] LPBO_ADDR_CONFIG = 8'h0C;
  localparam logic [7:0] LPBO_ADDR_INTENS = 8'h10;
  localparam logic [7:0] LPBO_ADDR_STATUS = 8'h14;
  localparam logic [7:0] LPBO_ADDR_BLINKP = 8'h18;
  localparam int LPBO_CFG_GLOBAL = 0;
  localparam int LPBO_CFG_BLINKEN = 1;
  localparam logic [3:0] LPBO_FULL = 4'hF;
  localparam logic [3:0] LPBO_SLOTS = 4'hF;
  localparam logic [7:0] LPBO_RST_MASTER = 8'h00;
  localparam logic [31:0] LPBO_RST_INTENS = 32'h0000_0000;
  localparam logic [15:0] LPBO_RST_BLINKP = 16'h0010;
  localparam int LPBO_SLOT_DIV = 4;
endpackage

// file: src/lpbo_channel.sv
`timescale 1ns/100ps
module lpbo_channel
  import lpbo_pkg::*;
(
  input wire logic [3:0] setting,
  input wire logic phaseBit,
  input wire logic [3:0] slot,
  input wire logic oscRun,
  output logic drvLow
);
  logic [4:0] lowSlots;

  always_comb
  begin
    // inverted phase uses complement count
    lowSlots = phaseBit ? {1'b0, LPBO_SLOTS - setting}
                        : {1'b0, setting} + 5'h01;
    if (setting == LPBO_FULL)
      drvLow = !phaseBit;
    else if (!oscRun)
      drvLow = !phaseBit;
    else
      drvLow = {1'b0, slot} < lowSlots;
  end
endmodule

// file: src/lpbo_top.sv
`timescale 1ns/100ps
module lpbo_top
  import lpbo_pkg::*;
#(
  parameter int NPORT = 8
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NPORT-1:0] portOutputsOe,
  output logic ninthOutputOe
);
  logic [8:0] phase0_q, phase0_d;
  logic [8:0] phase1_q, phase1_d;
  logic [7:0] master_q, master_d;
  logic [1:0] config_q, config_d;
  logic [31:0] intens_q, intens_d;
  logic [15:0] blinkPer_q, blinkPer_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [3:0] div_q, div_d;
  logic [3:0] slot_q, slot_d;
  logic [3:0] mslot_q, mslot_d;
  logic [15:0] blinkCnt_q, blinkCnt_d;
  logic blinkPhase_q, blinkPhase_d;
  logic [NPORT-1:0] portOe_q, portOe_d;
  logic ninthOe_q, ninthOe_d;
  logic oscRun, slotTick, masterGate;
  logic [NPORT:0] drvLow;
  logic [NPORT:0] fullSet;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  always_comb
  begin
    phase0_d = phase0_q;
    phase1_d = phase1_q;
    master_d = master_q;
    config_d = config_q;
    intens_d = intens_q;
    blinkPer_d = blinkPer_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    // one wait state: answer on the second edge after setup
    if (psel && penable && !pready_q)
    begin
      pready_d = 1'b1;
      prdata_d = 32'h0000_0000;
      if (hit(paddr, LPBO_ADDR_PHASE0))
      begin
        prdata_d = {23'h0, phase0_q};
        if (pwrite)
          phase0_d = pwdata[8:0];
      end
      else if (hit(paddr, LPBO_ADDR_PHASE1))
      begin
        prdata_d = {23'h0, phase1_q};
        if (pwrite)
          phase1_d = pwdata[8:0];
      end
      else if (hit(paddr, LPBO_ADDR_MASTER))
      begin
        prdata_d = {24'h0, master_q};
        if (pwrite)
          master_d = pwdata[7:0];
      end
      else if (hit(paddr, LPBO_ADDR_CONFIG))
      begin
        prdata_d = {30'h0, config_q};
        if (pwrite)
          config_d = pwdata[1:0];
      end
      else if (hit(paddr, LPBO_ADDR_INTENS))
      begin
        prdata_d = intens_q;
        if (pwrite)
          intens_d = pwdata;
      end
      else if (hit(paddr, LPBO_ADDR_BLINKP))
      begin
        prdata_d = {16'h0, blinkPer_q};
        if (pwrite)
          blinkPer_d = pwdata[15:0];
      end
      else if (hit(paddr, LPBO_ADDR_STATUS))
        prdata_d = {22'h0, oscRun, blinkPhase_q, 4'h0, slot_q};
      else
        pslverr_d = 1'b1;
    end
  end

  assign oscRun = master_q[7:4] != 4'h0;

  always_comb
  begin
    div_d = div_q;
    slot_d = slot_q;
    mslot_d = mslot_q;
    blinkCnt_d = blinkCnt_q;
    blinkPhase_d = blinkPhase_q;
    slotTick = 1'b0;
    if (oscRun)
    begin
      // divider gives a slot enable, oscillator halts when master_q[7:4] is zero
      div_d = (div_q == 4'(LPBO_SLOT_DIV - 1)) ? 4'h0 : div_q + 4'h1;
      slotTick = (div_q == 4'(LPBO_SLOT_DIV - 1));
    end
    if (slotTick)
    begin
      slot_d = slot_q + 4'h1;
      if (slot_q == LPBO_SLOTS)
      begin
        mslot_d = (mslot_q == 4'hE) ? 4'h0 : mslot_q + 4'h1;
        if (config_q[LPBO_CFG_BLINKEN])
        begin
          if (blinkCnt_q >= blinkPer_q)
          begin
            blinkCnt_d = 16'h0000;
            blinkPhase_d = !blinkPhase_q;
          end
          else
            blinkCnt_d = blinkCnt_q + 16'h0001;
        end
      end
    end
    if (!config_q[LPBO_CFG_BLINKEN])
    begin
      blinkCnt_d = 16'h0000;
      blinkPhase_d = 1'b0;
    end
  end

  // master time slot gating: m of 15 periods carry the pwm
  assign masterGate = !oscRun || (mslot_q < master_q[7:4]) ||
                      (master_q[7:4] == 4'hF);

  genvar gi;
  generate
    for (gi = 0; gi <= NPORT; gi++)
    begin : g_ch
      // ninth lane has no field of its own; keep the select in range
      localparam int IDX = (gi < NPORT) ? gi : 0;
      logic [3:0] setting;
      logic phaseBit;
      always_comb
      begin
        if (config_q[LPBO_CFG_GLOBAL])
          setting = master_q[3:0];
        else if (gi == NPORT)
          setting = master_q[3:0];
        else
          setting = intens_q[4*IDX +: 4];
        // shared phase registers for ports, own bit for ninth
        phaseBit = blinkPhase_q ? phase1_q[gi] : phase0_q[gi];
      end
      lpbo_channel lpbo_channel_i
      (
        .setting(setting),
        .phaseBit(phaseBit),
        .slot(slot_q),
        .oscRun(oscRun),
        .drvLow(drvLow[gi])
      );
      assign fullSet[gi] = setting == LPBO_FULL;
    end
  endgenerate

  always_comb
  begin
    // a full setting is static, so the master time slots do not gate it
    portOe_d = drvLow[NPORT-1:0] &
               ({NPORT{masterGate}} | fullSet[NPORT-1:0]);
    ninthOe_d = drvLow[NPORT] & (masterGate | fullSet[NPORT]);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phase0_q <= 9'h000;
      phase1_q <= 9'h000;
      master_q <= LPBO_RST_MASTER;
      config_q <= 2'h0;
      intens_q <= LPBO_RST_INTENS;
      blinkPer_q <= LPBO_RST_BLINKP;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      div_q <= 4'h0;
      slot_q <= 4'h0;
      mslot_q <= 4'h0;
      blinkCnt_q <= 16'h0000;
      blinkPhase_q <= 1'b0;
      portOe_q <= '0;
      ninthOe_q <= 1'b0;
    end
    else
    begin
      phase0_q <= phase0_d;
      phase1_q <= phase1_d;
      master_q <= master_d;
      config_q <= config_d;
      intens_q <= intens_d;
      blinkPer_q <= blinkPer_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      div_q <= div_d;
      slot_q <= slot_d;
      mslot_q <= mslot_d;
      blinkCnt_q <= blinkCnt_d;
      blinkPhase_q <= blinkPhase_d;
      portOe_q <= portOe_d;
      ninthOe_q <= ninthOe_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign portOutputsOe = portOe_q;
  assign ninthOutputOe = ninthOe_q;

  a_full_static: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (g_ch[0].setting == LPBO_FULL && !g_ch[0].phaseBit)
    |=> portOutputsOe[0]) else $error("full setting not low");
  a_full_off: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (g_ch[7].setting == LPBO_FULL && g_ch[7].phaseBit)
    |=> !portOutputsOe[7]) else $error("full setting not off");
  a_osc_stop: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !oscRun |=> $stable(slot_q)) else $error("slot moved with osc off");
  a_osc_static: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !oscRun |=> portOutputsOe[0] == !$past(g_ch[0].phaseBit))
    else $error("static level wrong with osc off");
  a_ninth_sep: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (master_q[7:4] == 4'hF && master_q[3:0] == LPBO_FULL &&
     !config_q[LPBO_CFG_GLOBAL] && blinkPhase_q && phase1_q[NPORT])
    |=> !ninthOutputOe) else $error("ninth not off");
  a_ninth_on: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (g_ch[NPORT].setting == LPBO_FULL && !g_ch[NPORT].phaseBit)
    |=> ninthOutputOe) else $error("ninth not on");
  a_half_duty: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (oscRun && masterGate && g_ch[7].setting == 4'h7 && slot_q == 4'h7)
    |=> portOutputsOe[7]) else $error("half duty wrong");
  a_half_off: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (oscRun && g_ch[7].setting == 4'h7 && slot_q == 4'h8)
    |=> !portOutputsOe[7]) else $error("half duty too long");
  a_low_slot: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (oscRun && masterGate && g_ch[0].setting == 4'h0 &&
     !g_ch[0].phaseBit && slot_q == 4'h1)
    |=> !portOutputsOe[0]) else $error("low time too long");
  a_low_first: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (oscRun && masterGate && g_ch[0].setting == 4'h0 &&
     !g_ch[0].phaseBit && slot_q == 4'h0)
    |=> portOutputsOe[0]) else $error("low time missing");
  a_inv_slot: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (oscRun && masterGate && g_ch[0].setting == 4'h0 &&
     g_ch[0].phaseBit && slot_q == 4'hE)
    |=> portOutputsOe[0]) else $error("inverted low time short");
  a_inv_end: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (oscRun && g_ch[0].setting == 4'h0 && g_ch[0].phaseBit &&
     slot_q == 4'hF)
    |=> !portOutputsOe[0]) else $error("inverted low time long");
  a_high_slot: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (oscRun && masterGate && g_ch[6].setting == 4'hE &&
     !g_ch[6].phaseBit && slot_q == 4'hE)
    |=> portOutputsOe[6]) else $error("high duty short");
  a_master_gate: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (oscRun && !masterGate && g_ch[0].setting != LPBO_FULL)
    |=> !portOutputsOe[0]) else $error("gated cycle not off");
  a_global_sel: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    config_q[LPBO_CFG_GLOBAL] |-> g_ch[1].setting == master_q[3:0])
    else $error("global not used");
  a_own_sel: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !config_q[LPBO_CFG_GLOBAL] |-> g_ch[2].setting == intens_q[11:8])
    else $error("own setting not used");
  a_blink_flip: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (slotTick && slot_q == LPBO_SLOTS && config_q[LPBO_CFG_BLINKEN] &&
     blinkCnt_q >= blinkPer_q) |=> blinkPhase_q != $past(blinkPhase_q))
    else $error("phase did not toggle");
  a_blink_off: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !config_q[LPBO_CFG_BLINKEN] |=> !blinkPhase_q)
    else $error("phase left set with blink off");
  a_slot_step: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    slotTick |=> slot_q == 4'($past(slot_q) + 4'h1))
    else $error("slot did not step");
  a_apb_wait: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (psel && penable && !pready) |=> pready) else $error("no ready");
  a_ready_pulse: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    pready |=> !pready) else $error("ready held too long");
  a_err_ready: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    pslverr |-> pready) else $error("error without ready");
endmodule

// file: tb/lpbo_led_load.sv
`timescale 1ns/100ps
module lpbo_led_load
(
  input wire logic sys_clk,
  input wire logic clearCnt,
  input wire logic [7:0] portOutputsOe,
  input wire logic ninthOutputOe,
  output logic [10:0] lowCnt [9],
  output logic [10:0] splitCnt
);
  // pulled-up open-drain pins: low only while driven
  logic [8:0] pinLevel;
  logic split;
  assign pinLevel = ~{ninthOutputOe, portOutputsOe};
  // a shared heavy load needs all port pins to switch as one
  assign split = |pinLevel[7:0] && !(&pinLevel[7:0]);
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < 9; i++)
      lowCnt[i] <= (clearCnt ? 11'h000 : lowCnt[i]) + 11'(!pinLevel[i]);
    splitCnt <= (clearCnt ? 11'h000 : splitCnt) + 11'(split);
  end
endmodule

// file: tb/tb_lpbo_top.sv
`timescale 1ns/100ps
module tb_lpbo_top;
  import lpbo_pkg::*;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, ninthOutputOe, clearCnt = 0, err;
  logic [7:0] portOutputsOe;
  logic [10:0] lowCnt [9];
  logic [10:0] splitCnt;
  int n_fail = 0, n_checks = 0;
  always #5 sys_clk = ~sys_clk;
  lpbo_top lpbo_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portOutputsOe(portOutputsOe), .ninthOutputOe(ninthOutputOe));
  lpbo_led_load lpbo_led_load_i (.sys_clk(sys_clk), .clearCnt(clearCnt),
    .portOutputsOe(portOutputsOe), .ninthOutputOe(ninthOutputOe),
    .lowCnt(lowCnt), .splitCnt(splitCnt));
  task check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do
    begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) check("pready", 1, 0);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  function automatic logic [10:0] lowExp(logic [3:0] n, logic ph, int len);
    if (n == LPBO_FULL) return ph ? 11'h000 : 11'(len);
    return 11'((ph ? 15 - n : n + 1) * len / 16);
  endfunction
  task measure(logic [10:0] exp [9], int len);
    repeat (64) @(posedge sys_clk);
    clearCnt <= 1;
    @(posedge sys_clk);
    clearCnt <= 0;
    repeat (len) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) check("low time", 32'(exp[i]), 32'(lowCnt[i]));
  endtask
  task duty(logic [3:0] base, logic ph);
    logic [10:0] exp [9];
    logic [31:0] d;
    for (int i = 0; i < 8; i++)
    begin
      d[4*i +: 4] = base + 4'(i);
      exp[i] = lowExp(base + 4'(i), ph, 960);
    end
    exp[8] = lowExp(base + 4'h3, ph, 960);
    apb(1, LPBO_ADDR_PHASE0, ph ? 32'h1FF : 32'h0);
    apb(1, LPBO_ADDR_MASTER, {24'h0, 4'hF, base + 4'h3});
    apb(1, LPBO_ADDR_INTENS, d);
    measure(exp, 960);
  endtask
  task gating;
    logic [10:0] exp [9];
    apb(1, LPBO_ADDR_CONFIG, 32'h0);
    apb(1, LPBO_ADDR_PHASE0, 32'h0);
    apb(1, LPBO_ADDR_MASTER, 32'h8F);
    apb(1, LPBO_ADDR_INTENS, 32'h0000_00F3);
    for (int i = 0; i < 9; i++) exp[i] = 11'(lowExp(4'h0, 0, 960) * 8 / 15);
    exp[0] = 11'(lowExp(4'h3, 0, 960) * 8 / 15);
    exp[1] = lowExp(LPBO_FULL, 0, 960);
    exp[8] = lowExp(LPBO_FULL, 0, 960);
    measure(exp, 960);
  endtask
  task others;
    logic [10:0] exp [9];
    apb(1, LPBO_ADDR_PHASE0, 32'h0);
    apb(1, LPBO_ADDR_CONFIG, 32'h1);
    apb(1, LPBO_ADDR_MASTER, 32'hF3);
    for (int i = 0; i < 9; i++) exp[i] = lowExp(4'h3, 0, 960);
    measure(exp, 960);
    apb(1, LPBO_ADDR_CONFIG, 32'h0);
    apb(1, LPBO_ADDR_PHASE0, 32'h0AA);
    apb(1, LPBO_ADDR_MASTER, 32'h05);
    for (int i = 0; i < 9; i++) exp[i] = lowExp(4'hF, i % 2 == 1, 960);
    measure(exp, 960);
    apb(1, LPBO_ADDR_CONFIG, 32'h2);
    apb(1, LPBO_ADDR_BLINKP, 32'h0);
    apb(1, LPBO_ADDR_PHASE0, 32'h0);
    apb(1, LPBO_ADDR_PHASE1, 32'h1FF);
    apb(1, LPBO_ADDR_MASTER, 32'hFF);
    apb(1, LPBO_ADDR_INTENS, 32'hFFFFFFFF);
    for (int i = 0; i < 9; i++) exp[i] = 11'd128;
    measure(exp, 256);
    check("port split", 0, 32'(splitCnt));
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 0;
    repeat (2) @(posedge sys_clk);
    check("oe reset", 32'h1FF, {ninthOutputOe, portOutputsOe});
    apb(0, LPBO_ADDR_BLINKP, 32'h0);
    check("blink reset", 32'(LPBO_RST_BLINKP), q);
    apb(0, 8'h40, 32'h0);
    check("unmapped", 32'h1, {31'h0, err});
    for (int b = 0; b < 2; b++)
    begin
      duty(4'h0, b[0]);
      duty(4'h8, b[0]);
    end
    gating;
    others;
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    give_verdict;
  end
endmodule
